// >>> pkg/epiw_pkg.sv
/*
 * constants and types for the external pin interrupt, wake and
 * context shadow block.
 * assumes a 32-bit axi4-lite register bus and one system clock.
 */
package epiw_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_STAT        = 8'h04;
  localparam logic [7:0] ADDR_SHADOW_BASE = 8'h40;
  localparam int         SHADOW_COUNT     = 8;

  // ----------------------------------------------------------------
  // irq_control_reg fields and reset value
  // ----------------------------------------------------------------
  localparam int         CTRL_GIE_BIT      = 0;
  localparam int         CTRL_EXT_EN_BIT   = 1;
  localparam int         CTRL_EXT_FLAG_BIT = 2;
  localparam int         CTRL_EDGE_BIT     = 3;
  localparam int         CTRL_PEN_LSB      = 4;
  localparam logic [7:0] CTRL_RESET        = 8'h00;

  // status register fields
  localparam int         STAT_SLEEP_BIT    = 0;
  localparam int         STAT_HANDLER_BIT  = 1;
  localparam int         STAT_PEND_BIT     = 2;
  localparam int         STAT_PREQ_LSB     = 4;

  // ----------------------------------------------------------------
  // peripheral sources; the low ones keep running without a clock
  // ----------------------------------------------------------------
  localparam int         PERIPH_COUNT      = 4;
  localparam logic [3:0] WAKE_CAPABLE_MASK = 4'h3;

  // ----------------------------------------------------------------
  // shadow slots; timeout and sleep-entered bits are never shadowed
  // ----------------------------------------------------------------
  localparam int         SH_W             = 0;
  localparam int         SH_STATUS        = 1;
  localparam int         SH_BSR           = 2;
  localparam int         SH_FSR0L         = 3;
  localparam int         SH_FSR0H         = 4;
  localparam int         SH_FSR1L         = 5;
  localparam int         SH_FSR1H         = 6;
  localparam int         SH_PC_UPPER_LATCH        = 7;
  localparam logic [7:0] STATUS_KEEP_MASK = 8'h18;
  localparam logic [7:0] SHADOW_RESET     = 8'h00;
  localparam int         PC_WIDTH         = 15;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sequencing of the core around sleep and interrupt entry
  typedef enum logic [4:0] {
    ST_RUN       = 5'h01,
    ST_SLEEP     = 5'h02,
    ST_WAKE_STEP = 5'h04,
    ST_ENTRY     = 5'h08,
    ST_HANDLER   = 5'h10
  } epiw_state_t;

endpackage

// >>> rtl/epiw_edge_det.sv
/*
 * synchroniser and polarity-selectable edge detector for the
 * external interrupt pin.
 * assumes the pin is asynchronous to aclk.
 */
module epiw_edge_det (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin and edge choice
  input  wire logic pin_async,
  input  wire logic rising_sel,
  // detected edge, one cycle
  output wire logic edge_pulse
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // two-stage synchroniser, then one history stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // edge of the chosen polarity raises a request
  assign edge_pulse = rising_sel ? (sync2_reg & ~prev_reg)
                                 : (~sync2_reg & prev_reg);

endmodule

// >>> rtl/epiw_core.sv
/*
 * external pin interrupt, wake-from-sleep sequencing and automatic
 * context shadowing, with an axi4-lite register slave.
 * assumes the core reports instruction ends, sleep, return and live
 * register values on aclk, and acts on the pulses it gets back.
 */
// Overview of operation
// - only sources that run without system clock may wake from sleep
// - a source wakes only if its enable was set before sleep
// - after wake, vector if global enable set, else continue onward
// - the instruction after sleep always executes before any vectoring
// - external pin gives an asynchronous edge request, gated by its enable
// - edge select set picks rising edge, cleared picks falling
// - a valid edge sets the external flag regardless of enables
// - flag with global and external enables redirects to the vector
// - interrupt entry pushes the return address onto the stack
// - entry copies w, status less two bits, bank, pointers, pc latch
// - return restores all shadowed registers, dropping handler changes
// - software reads and writes the shadows; writes become restored
module epiw_core (
  // clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // interrupt sources
  input  wire logic                       ext_irq_pin,
  input  wire logic [3:0]                 periph_req,
  // core events
  input  wire logic                       instr_done,
  input  wire logic                       sleep_exec,
  input  wire logic                       irq_return,
  input  wire logic [epiw_pkg::PC_WIDTH-1:0] return_pc,
  // live core registers
  input  wire logic [7:0]                 live_w,
  input  wire logic [7:0]                 live_status,
  input  wire logic [7:0]                 live_bsr,
  input  wire logic [15:0]                live_fsr0,
  input  wire logic [15:0]                live_fsr1,
  input  wire logic [7:0]                 live_pc_latch,
  // sequencing back to the core
  output logic                            core_sleeping,
  output logic                            core_wake,
  output logic                            vector_take,
  output logic                            stack_push,
  output logic [epiw_pkg::PC_WIDTH-1:0]   stack_push_addr,
  // restore values, taken while restore_valid is high
  output logic                            restore_valid,
  output logic [7:0]                      restore_w,
  output logic [7:0]                      restore_status,
  output logic [7:0]                      restore_bsr,
  output logic [15:0]                     restore_fsr0,
  output logic [15:0]                     restore_fsr1,
  output logic [7:0]                      restore_pc_latch
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  epiw_pkg::epiw_state_t state_reg, state_next;
  logic        aw_free_reg, w_free_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic        gie_reg, ext_en_reg, edge_sel_reg, ext_flag_reg;
  logic [3:0]  periph_en_reg, snap_periph_reg;
  logic        snap_ext_reg;
  logic        wake_reg, vector_reg, push_reg, restore_reg, sleep_reg;
  logic [epiw_pkg::PC_WIDTH-1:0] push_addr_reg;
  logic [7:0]  shadow_mem [epiw_pkg::SHADOW_COUNT];
  logic [7:0]  live_bytes [epiw_pkg::SHADOW_COUNT];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic       edge_pulse;
  wire logic       wr_fire   = !aw_free_reg && !w_free_reg && !bvalid_reg;
  wire logic       wr_lane0  = wr_fire && wstrb_reg[0];
  wire logic       wr_is_sh  = awaddr_reg[7:5] ==
                               epiw_pkg::ADDR_SHADOW_BASE[7:5]
                               && awaddr_reg[1:0] == 2'h0;
  wire logic       wr_ctrl   = wr_lane0 && awaddr_reg == epiw_pkg::ADDR_CTRL;
  wire logic       wr_shadow = wr_lane0 && wr_is_sh;
  wire logic [2:0] wr_idx    = awaddr_reg[4:2];
  wire logic       wr_ok     = wr_is_sh || awaddr_reg == epiw_pkg::ADDR_CTRL
                               || awaddr_reg == epiw_pkg::ADDR_STAT;
  wire logic       rd_take   = s_axi_arvalid && arready_reg;
  wire logic       rd_is_sh  = s_axi_araddr[7:5] ==
                               epiw_pkg::ADDR_SHADOW_BASE[7:5]
                               && s_axi_araddr[1:0] == 2'h0;
  wire logic [2:0] rd_idx    = s_axi_araddr[4:2];
  wire logic [7:0] ctrl_view = {periph_en_reg, edge_sel_reg, ext_flag_reg,
                                ext_en_reg, gie_reg};
  wire logic       entering  = state_reg == epiw_pkg::ST_ENTRY;
  wire logic       returning = state_reg == epiw_pkg::ST_HANDLER && irq_return;
  wire logic       flag_clr  = wr_ctrl
                               && !wdata_reg[epiw_pkg::CTRL_EXT_FLAG_BIT];

  // pending request and the narrower set that may wake from sleep
  wire logic       irq_pend  = (ext_flag_reg && ext_en_reg)
                               || |(periph_req & periph_en_reg);
  wire logic       wake_req  = (ext_flag_reg && ext_en_reg
                                && snap_ext_reg)
                               || |(periph_req & periph_en_reg
                                    & snap_periph_reg
                                    & epiw_pkg::WAKE_CAPABLE_MASK);
  wire logic       take_irq  = instr_done && gie_reg && irq_pend;

  // live values in shadow slot order; timeout and sleep bits dropped
  assign live_bytes[epiw_pkg::SH_W]      = live_w;
  assign live_bytes[epiw_pkg::SH_STATUS] =
    live_status & ~epiw_pkg::STATUS_KEEP_MASK;
  assign live_bytes[epiw_pkg::SH_BSR]    = live_bsr;
  assign live_bytes[epiw_pkg::SH_FSR0L]  = live_fsr0[7:0];
  assign live_bytes[epiw_pkg::SH_FSR0H]  = live_fsr0[15:8];
  assign live_bytes[epiw_pkg::SH_FSR1L]  = live_fsr1[7:0];
  assign live_bytes[epiw_pkg::SH_FSR1H]  = live_fsr1[15:8];
  assign live_bytes[epiw_pkg::SH_PC_UPPER_LATCH] = live_pc_latch;

  // pin edge detection
  epiw_edge_det u_edge (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin_async  (ext_irq_pin),
    .rising_sel (edge_sel_reg),
    .edge_pulse (edge_pulse)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // next state of the sleep and entry sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      epiw_pkg::ST_RUN: begin
        if (take_irq)
          state_next = epiw_pkg::ST_ENTRY;
        else if (sleep_exec)
          state_next = epiw_pkg::ST_SLEEP;
      end
      epiw_pkg::ST_SLEEP: begin
        if (wake_req)
          state_next = epiw_pkg::ST_WAKE_STEP;
      end
      epiw_pkg::ST_WAKE_STEP: begin
        if (instr_done)
          state_next = take_irq ? epiw_pkg::ST_ENTRY
                                : epiw_pkg::ST_RUN;
      end
      epiw_pkg::ST_ENTRY:   state_next = epiw_pkg::ST_HANDLER;
      epiw_pkg::ST_HANDLER: begin
        if (irq_return)
          state_next = epiw_pkg::ST_RUN;
      end
    endcase
  end

  // state, sleep snapshot of enables and core pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg       <= epiw_pkg::ST_RUN;
      snap_ext_reg    <= 1'b0;
      snap_periph_reg <= 4'h0;
      wake_reg        <= 1'b0;
      vector_reg      <= 1'b0;
      push_reg        <= 1'b0;
      push_addr_reg   <= '0;
      restore_reg     <= 1'b0;
      sleep_reg       <= 1'b0;
    end else begin
      state_reg   <= state_next;
      sleep_reg   <= state_next == epiw_pkg::ST_SLEEP;  // flop-driven level
      wake_reg    <= state_reg == epiw_pkg::ST_SLEEP && wake_req;
      vector_reg  <= entering;
      push_reg    <= entering;
      restore_reg <= returning;
      if (state_reg == epiw_pkg::ST_RUN && sleep_exec && !take_irq) begin
        snap_ext_reg    <= ext_en_reg;
        snap_periph_reg <= periph_en_reg;
      end
      if (entering)
        push_addr_reg <= return_pc;
    end
  end

  // ----------------------------------------------------------------
  // control bits and flag
  // ----------------------------------------------------------------
  // hardware events win over software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {periph_en_reg, edge_sel_reg, ext_flag_reg, ext_en_reg, gie_reg}
        <= epiw_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        gie_reg       <= wdata_reg[epiw_pkg::CTRL_GIE_BIT];
        ext_en_reg    <= wdata_reg[epiw_pkg::CTRL_EXT_EN_BIT];
        edge_sel_reg  <= wdata_reg[epiw_pkg::CTRL_EDGE_BIT];
        periph_en_reg <= wdata_reg[epiw_pkg::CTRL_PEN_LSB +: 4];
      end
      if (entering)
        gie_reg <= 1'b0;
      else if (returning)
        gie_reg <= 1'b1;
      if (edge_pulse)
        ext_flag_reg <= 1'b1;
      else if (flag_clr)
        ext_flag_reg <= 1'b0;
      else if (wr_ctrl)
        ext_flag_reg <= wdata_reg[epiw_pkg::CTRL_EXT_FLAG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // shadow registers
  // ----------------------------------------------------------------
  // each slot: entry capture first, else a software write
  for (genvar i = 0; i < epiw_pkg::SHADOW_COUNT; i++) begin : g_shadow
    always_ff @(posedge aclk) begin
      if (!aresetn)
        shadow_mem[i] <= epiw_pkg::SHADOW_RESET;
      else if (entering)
        shadow_mem[i] <= live_bytes[i];
      else if (wr_shadow && wr_idx == 3'(i))
        shadow_mem[i] <= wdata_reg[7:0];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  // write side: hold address and data, answer once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_free_reg <= 1'b1;
      w_free_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= epiw_pkg::RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && aw_free_reg) begin
        aw_free_reg <= 1'b0;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && w_free_reg) begin
        w_free_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? epiw_pkg::RESP_OKAY : epiw_pkg::RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        aw_free_reg <= 1'b1;
        w_free_reg  <= 1'b1;
      end
    end
  end

  // read side: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= epiw_pkg::RESP_OKAY;
    end else if (rd_take) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= epiw_pkg::RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
      if (rd_is_sh)
        rdata_reg[7:0] <= shadow_mem[rd_idx];
      else if (s_axi_araddr == epiw_pkg::ADDR_CTRL)
        rdata_reg[7:0] <= ctrl_view;
      else if (s_axi_araddr == epiw_pkg::ADDR_STAT) begin
        rdata_reg[epiw_pkg::STAT_SLEEP_BIT]   <= core_sleeping;
        rdata_reg[epiw_pkg::STAT_HANDLER_BIT] <=
          state_reg == epiw_pkg::ST_HANDLER;
        rdata_reg[epiw_pkg::STAT_PEND_BIT]    <= irq_pend;
        rdata_reg[epiw_pkg::STAT_PREQ_LSB +: 4] <= periph_req;
      end else
        rresp_reg <= epiw_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign s_axi_awready    = aw_free_reg;
  assign s_axi_wready     = w_free_reg;
  assign s_axi_bvalid     = bvalid_reg;
  assign s_axi_bresp      = bresp_reg;
  assign s_axi_arready    = arready_reg;
  assign s_axi_rvalid     = rvalid_reg;
  assign s_axi_rdata      = rdata_reg;
  assign s_axi_rresp      = rresp_reg;
  assign core_sleeping    = sleep_reg;
  assign core_wake        = wake_reg;
  assign vector_take      = vector_reg;
  assign stack_push       = push_reg;
  assign stack_push_addr  = push_addr_reg;
  assign restore_valid    = restore_reg;
  assign restore_w        = shadow_mem[epiw_pkg::SH_W];
  assign restore_status   = shadow_mem[epiw_pkg::SH_STATUS];
  assign restore_bsr      = shadow_mem[epiw_pkg::SH_BSR];
  assign restore_fsr0     = {shadow_mem[epiw_pkg::SH_FSR0H],
                             shadow_mem[epiw_pkg::SH_FSR0L]};
  assign restore_fsr1     = {shadow_mem[epiw_pkg::SH_FSR1H],
                             shadow_mem[epiw_pkg::SH_FSR1L]};
  assign restore_pc_latch = shadow_mem[epiw_pkg::SH_PC_UPPER_LATCH];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_wake_then_step;
    state_reg == epiw_pkg::ST_SLEEP && wake_req
    ##1 state_reg == epiw_pkg::ST_WAKE_STEP && core_wake;
  endsequence

  property p_sleep_hold;
    @(posedge aclk) disable iff (!aresetn)
    state_reg == epiw_pkg::ST_SLEEP && !wake_req
    |=> state_reg == epiw_pkg::ST_SLEEP;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("left sleep without an armed wake source");

  property p_step_first;
    @(posedge aclk) disable iff (!aresetn)
    s_wake_then_step ##0 !instr_done |=> state_reg != epiw_pkg::ST_ENTRY;
  endproperty
  a_step_first: assert property (p_step_first)
    else $error("vectored before the instruction after sleep");

  property p_wake_no_gie;
    @(posedge aclk) disable iff (!aresetn)
    state_reg == epiw_pkg::ST_WAKE_STEP && instr_done && !gie_reg
    |=> state_reg == epiw_pkg::ST_RUN ##1 !vector_take;
  endproperty
  a_wake_no_gie: assert property (p_wake_no_gie)
    else $error("wake without global enable did not resume");

  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn)
    edge_pulse |=> ext_flag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("valid pin edge did not set the flag");

  property p_flag_hold;
    @(posedge aclk) disable iff (!aresetn)
    ext_flag_reg && !flag_clr |=> ext_flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without a clear");

  property p_redirect;
    @(posedge aclk) disable iff (!aresetn)
    state_reg == epiw_pkg::ST_RUN && instr_done && gie_reg
    && ext_flag_reg && ext_en_reg
    |=> entering ##1 vector_take && stack_push;
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("enabled flag did not redirect to the vector");

  property p_push_addr;
    @(posedge aclk) disable iff (!aresetn)
    entering |=> stack_push && stack_push_addr == $past(return_pc);
  endproperty
  a_push_addr: assert property (p_push_addr)
    else $error("return address not pushed on entry");

  property p_capture;
    @(posedge aclk) disable iff (!aresetn)
    entering |=> restore_w == $past(live_w) && restore_fsr1 ==
      $past(live_fsr1) && (restore_status & epiw_pkg::STATUS_KEEP_MASK)
      == 8'h00;
  endproperty
  a_capture: assert property (p_capture)
    else $error("shadow copy on entry is wrong");

  property p_restore;
    @(posedge aclk) disable iff (!aresetn)
    returning |=> restore_valid && gie_reg ##1 !restore_valid;
  endproperty
  a_restore: assert property (p_restore)
    else $error("return did not give a one-cycle restore");

  property p_shadow_write;
    @(posedge aclk) disable iff (!aresetn)
    wr_shadow && !entering
    |=> shadow_mem[$past(wr_idx)] == $past(wdata_reg[7:0]);
  endproperty
  a_shadow_write: assert property (p_shadow_write)
    else $error("software shadow write lost");

endmodule

// >>> test/epiw_pin_src.sv
/* pin source model driving the external interrupt pin.
   assumes the bench sets lvl and dly on aclk. */
module epiw_pin_src (
  // clock
  input  wire logic       aclk,
  // requested level, delay in cycles
  input  wire logic       lvl,
  input  wire logic [1:0] dly,
  // pin
  output logic            pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // follow each request late and off the edge
  initial pin = 1'b0;
  always begin
    @(lvl);
    @(posedge aclk);
    repeat (dly) @(posedge aclk);
    #3 pin = lvl;
  end
endmodule

// >>> test/tb_top.sv
/* self-checking bench for epiw_core.
   assumes epiw_pkg and the design files are compiled first. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [7:0] CT = epiw_pkg::ADDR_CTRL;
  localparam logic [1:0] OK = epiw_pkg::RESP_OKAY;
  logic aclk, aresetn, lvl, pin, instr_done, sleep_exec, irq_return;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, core_sleeping, core_wake;
  logic vector_take, stack_push, restore_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, dly;
  logic [3:0] s_axi_wstrb, periph_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr, live_w, live_status, live_bsr;
  logic [7:0] live_pc_latch, restore_w, restore_status, restore_bsr;
  logic [7:0] restore_pc_latch;
  logic [15:0] live_fsr0, live_fsr1, restore_fsr0, restore_fsr1;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [epiw_pkg::PC_WIDTH-1:0] return_pc, stack_push_addr;
  int num_errors, cmp_count, n_vec, n_wake, n_rst, m_sh[8];

  epiw_core i_dut (.ext_irq_pin(pin), .*);
  epiw_pin_src i_src (.aclk(aclk), .lvl(lvl), .dly(dly), .pin(pin));

  // ------------------------------------------------------------
  // clock, pulse counters and tasks
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (vector_take === 1'b1 && stack_push === 1'b1) n_vec <= n_vec + 1;
    if (core_wake === 1'b1) n_wake <= n_wake + 1;
    if (restore_valid === 1'b1) n_rst <= n_rst + 1;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task finish_test;
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(OK));
    @(posedge aclk);
  endtask
  task core(input logic [2:0] v);
    {irq_return, sleep_exec, instr_done} <= v;
    @(posedge aclk);
    {irq_return, sleep_exec, instr_done} <= 3'h0;
    repeat (4) @(posedge aclk);
  endtask
  task pedge(input logic v);
    lvl <= v;
    dly <= 2'($urandom);
    repeat (10) @(posedge aclk);
  endtask
  initial begin
    #100us;
    num_errors++;
    finish_test;
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, instr_done, sleep_exec} = '0;
    {irq_return, lvl, dly, periph_req, s_axi_wdata} = '0;
    {s_axi_awaddr, s_axi_araddr, return_pc, live_w, live_status} = '0;
    {live_bsr, live_fsr0, live_fsr1, live_pc_latch} = '0;
    {num_errors, cmp_count, n_vec, n_wake, n_rst} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'h6D21));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CT, 32'h0);
    wr(8'h80, 32'h1, epiw_pkg::RESP_SLVERR);
    for (int e = 0; e < 2; e++) begin
      wr(CT, 32'(e * 8), OK);
      pedge(~e[0]);
      rd(CT, 32'(e * 8));
      pedge(e[0]);
      rd(CT, 32'(e * 8 + 4));
      pedge(~e[0]);
      pedge(e[0]);
      wr(CT, 32'(e * 8), OK);
      rd(CT, 32'(e * 8));
    end
    // entry with random context, shadow edit, return
    {live_w, live_status, live_bsr} <= 24'($urandom);
    live_fsr0 <= 16'($urandom);
    {live_fsr1, live_pc_latch} <= 24'($urandom);
    return_pc <= 15'($urandom);
    wr(CT, 32'h0B, OK);
    pedge(1'b0);
    pedge(1'b1);
    m_sh = '{live_w, live_status & ~epiw_pkg::STATUS_KEEP_MASK, live_bsr,
      live_fsr0[7:0], live_fsr0[15:8], live_fsr1[7:0], live_fsr1[15:8],
      live_pc_latch};
    core(3'h1);
    chk(32'(n_vec), 32'h1);
    chk(32'(stack_push_addr), 32'(return_pc));
    for (int i = 0; i < 8; i++) rd(8'(64 + 4 * i), 32'(m_sh[i]));
    m_sh[0] = int'($urandom % 256);
    wr(8'h40, 32'(m_sh[0]), OK);
    live_w <= ~live_w;
    core(3'h4);
    chk({restore_w, restore_status, restore_fsr0}, {m_sh[0][7:0],
      m_sh[1][7:0], m_sh[4][7:0], m_sh[3][7:0]});
    chk({restore_bsr, restore_fsr1, restore_pc_latch}, {m_sh[2][7:0],
      m_sh[6][7:0], m_sh[5][7:0], m_sh[7][7:0]});
    chk(32'(n_rst), 32'h1);
    rd(CT, 32'h0F);
    // sleep: disabled pin and clocked peripheral must not wake
    wr(CT, 32'h98, OK);
    core(3'h2);
    pedge(1'b0);
    pedge(1'b1);
    periph_req <= 4'h8;
    repeat (5) @(posedge aclk);
    chk(32'({core_sleeping, n_wake[3:0]}), 32'h10);
    rd(epiw_pkg::ADDR_STAT, 32'h85);
    periph_req <= 4'h1;
    repeat (3) @(posedge aclk);
    chk(32'(n_wake), 32'h1);
    core(3'h1);
    chk(32'({core_sleeping, n_vec[3:0]}), 32'h01);
    periph_req <= 4'h0;
    // sleep with global enable: vector only after next instruction
    wr(CT, 32'h0B, OK);
    core(3'h2);
    pedge(1'b0);
    pedge(1'b1);
    chk(32'({n_wake[3:0], n_vec[3:0]}), 32'h21);
    core(3'h1);
    chk(32'(n_vec), 32'h2);
    core(3'h4);
    finish_test;
  end
endmodule
